// *** core/dspace_pkg.sv ***
// constants for the data-space address decoder
package dspace_pkg;
    // ---------------------------------------------------------------
    // address map, 16-bit word addresses
    // ---------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam logic [23:0] RAM_BASE = 24'h00_0000;
    localparam logic [23:0] RAM_LAST = 24'h00_3FFF;
    localparam logic [23:0] DFLASH_BASE = 24'h00_4000;
    localparam logic [23:0] DFLASH_LAST = 24'h00_7FFF;
    localparam logic [23:0] PERIPH_BASE = 24'h00_F000;
    localparam logic [23:0] PERIPH_LAST = 24'h00_FFFF;
    localparam logic [23:0] DEBUG_BASE = 24'hFF_FF00;
    localparam logic [23:0] DEBUG_LOCK = 24'hFF_FFFC;
    localparam logic [23:0] DEBUG_XSC = 24'hFF_FFFD;
    localparam logic [23:0] DEBUG_XLO = 24'hFF_FFFE;
    localparam logic [23:0] DEBUG_XHI = 24'hFF_FFFF;
    // ---------------------------------------------------------------
    // program flash configuration words
    // ---------------------------------------------------------------
    localparam logic [23:0] CFG_FIRST = 24'h03_FFF7;
    localparam logic [23:0] CFG_LAST = 24'h03_FFFF;
    localparam int CFG_WORDS = 9;
    // ---------------------------------------------------------------
    // flash geometry, in words
    // ---------------------------------------------------------------
    localparam int PFLASH_SECTORS = 16;
    localparam int PFLASH_SECTOR_WORDS = 16384;
    localparam int PFLASH_PAGE_WORDS = 1024;
    localparam int DFLASH_SECTORS = 16;
    localparam int DFLASH_SECTOR_WORDS = 1024;
    localparam int DFLASH_PAGE_WORDS = 256;
    localparam int BFLASH_SECTORS = 4;
    localparam int BFLASH_SECTOR_WORDS = 4096;
    localparam int BFLASH_PAGE_WORDS = 512;
    // ---------------------------------------------------------------
    // ram shape
    // ---------------------------------------------------------------
    localparam int RAM_ENTRIES = 8192;
    localparam int RAM_WIDTH = 32;
    // ---------------------------------------------------------------
    // targets
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_RAM,
        TGT_DFLASH,
        TGT_PERIPH,
        TGT_DEBUG,
        TGT_EXT
    } target_t;
    typedef enum logic [2:0] {
        DBG_OTHER,
        DBG_LOCK,
        DBG_XSC,
        DBG_XLO,
        DBG_XHI
    } debug_reg_t;
    typedef enum {
        INIT_LOAD,
        INIT_DONE
    } init_state_t;
endpackage : dspace_pkg

// *** core/data_ram.sv ***
// on-chip data ram, long-word wide, registered read data
module data_ram #(
    parameter int ENTRIES = 8192,
    parameter int WIDTH = 32,
    parameter int AW = 13
) (
    input wire logic clk_sys,
    input wire logic [AW-1:0] addr,
    input wire logic wr_en,
    input wire logic [1:0] half_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [ENTRIES];
    always_ff @(posedge clk_sys) begin
        if (wr_en && half_en[0]) begin
            mem[addr][WIDTH/2-1:0] <= wr_data[WIDTH/2-1:0];
        end
        if (wr_en && half_en[1]) begin
            mem[addr][WIDTH-1:WIDTH/2] <= wr_data[WIDTH-1:WIDTH/2];
        end
        rd_data <= mem[addr];
    end
endmodule : data_ram

// *** core/data_space_decoder.sv ***
// data-space address decoder with on-chip ram and flash config load
// Contract
// - addresses are 16-bit word addresses
// - F000..FFFF always selects peripheral window
// - data ram is 8K by 32 bits
// - program and boot flash share controls
// - data flash has its own controls
// - load nine top flash words at init
// - flash sector and page geometry fixed
// - debug window register selects at top
// - memory disable removes low on-chip regions
module data_space_decoder #(
    parameter int AW = 24
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic internal_memory_disable,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic acc_long,
    input wire logic [23:0] acc_addr,
    input wire logic [31:0] acc_wdata,
    input wire logic [23:0] pbus_addr,
    input wire logic pbus_valid,
    input wire logic [15:0] pflash_rdata,
    output logic [2:0] target,
    output logic sel_ram,
    output logic sel_dflash,
    output logic sel_periph,
    output logic sel_debug,
    output logic sel_ext,
    output logic [2:0] debug_reg,
    output logic [11:0] periph_offset,
    output logic [14:0] dflash_offset,
    output logic [3:0] dflash_sector,
    output logic [7:0] dflash_page_word,
    output logic pbus_to_boot_or_prog,
    output logic [3:0] pflash_sector,
    output logic [9:0] pflash_page_word,
    output logic [31:0] ram_rdata,
    output logic [23:0] cfg_fetch_addr,
    output logic cfg_fetch_valid,
    output logic [15:0] flash_ctrl_cfg [dspace_pkg::CFG_WORDS],
    output logic init_done
);
    import dspace_pkg::*;

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    target_t tgt_c;
    debug_reg_t dreg_c;
    target_t target_reg, target_next;
    debug_reg_t debug_reg_reg, debug_reg_next;
    logic [11:0] poff_reg, poff_next;
    logic [14:0] dfoff_reg, dfoff_next;
    logic [3:0] psec_reg, psec_next;
    logic [9:0] ppw_reg, ppw_next;
    logic pbus_reg, pbus_next;
    logic [4:0] sel_reg, sel_next;

    always_comb begin
        // comparisons are on word addresses; no byte shift anywhere
        tgt_c = TGT_NONE;
        dreg_c = DBG_OTHER;
        if (!acc_valid) begin
            tgt_c = TGT_NONE;
        end else if (acc_addr >= PERIPH_BASE && acc_addr <= PERIPH_LAST) begin
            tgt_c = TGT_PERIPH;
        end else if (acc_addr >= DEBUG_BASE) begin
            tgt_c = TGT_DEBUG;
        end else if (!internal_memory_disable && acc_addr <= RAM_LAST) begin
            tgt_c = TGT_RAM;
        end else if (!internal_memory_disable && acc_addr >= DFLASH_BASE
                     && acc_addr <= DFLASH_LAST) begin
            tgt_c = TGT_DFLASH;
        end else begin
            tgt_c = TGT_EXT;
        end
        case (acc_addr)
            DEBUG_LOCK: dreg_c = DBG_LOCK;
            DEBUG_XSC: dreg_c = DBG_XSC;
            DEBUG_XLO: dreg_c = DBG_XLO;
            DEBUG_XHI: dreg_c = DBG_XHI;
            default: dreg_c = DBG_OTHER;
        endcase
        if (tgt_c != TGT_DEBUG) begin
            dreg_c = DBG_OTHER;
        end
        target_next = tgt_c;
        debug_reg_next = dreg_c;
        // selects get flops of their own, so no decode sits between register and pin
        sel_next = {tgt_c == TGT_RAM, tgt_c == TGT_DFLASH, tgt_c == TGT_PERIPH,
                    tgt_c == TGT_DEBUG, tgt_c == TGT_EXT};
        poff_next = acc_addr[11:0];
        dfoff_next = acc_addr[14:0] - DFLASH_BASE[14:0];
        // program and boot flash sit on the program bus, one control set
        pbus_next = pbus_valid;
        psec_next = pbus_addr[17:14];
        ppw_next = pbus_addr[9:0];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            target_reg <= TGT_NONE;
            debug_reg_reg <= DBG_OTHER;
            poff_reg <= '0;
            dfoff_reg <= '0;
            psec_reg <= '0;
            ppw_reg <= '0;
            pbus_reg <= 1'b0;
            sel_reg <= '0;
        end else begin
            target_reg <= target_next;
            debug_reg_reg <= debug_reg_next;
            poff_reg <= poff_next;
            dfoff_reg <= dfoff_next;
            psec_reg <= psec_next;
            ppw_reg <= ppw_next;
            pbus_reg <= pbus_next;
            sel_reg <= sel_next;
        end
    end

    assign target = target_reg;
    assign sel_ram = sel_reg[4];
    assign sel_dflash = sel_reg[3];
    assign sel_periph = sel_reg[2];
    assign sel_debug = sel_reg[1];
    assign sel_ext = sel_reg[0];
    assign debug_reg = debug_reg_reg;
    assign periph_offset = poff_reg;
    assign dflash_offset = dfoff_reg;
    // 1024-word sectors of 256-word pages
    assign dflash_sector = dfoff_reg[13:10];
    assign dflash_page_word = dfoff_reg[7:0];
    assign pbus_to_boot_or_prog = pbus_reg;
    assign pflash_sector = psec_reg;
    assign pflash_page_word = ppw_reg;

    // ---------------------------------------------------------------
    // data ram: a long word is one entry, a word one half of it
    // ---------------------------------------------------------------
    logic ram_we;
    logic [1:0] ram_half;
    logic [31:0] ram_wd;
    always_comb begin
        ram_we = acc_valid && acc_write && (tgt_c == TGT_RAM);
        ram_half = acc_long ? 2'b11 : (acc_addr[0] ? 2'b10 : 2'b01);
        ram_wd = acc_long ? acc_wdata : {acc_wdata[15:0], acc_wdata[15:0]};
    end

    data_ram #(
        .ENTRIES(RAM_ENTRIES),
        .WIDTH(RAM_WIDTH),
        .AW(13)
    ) u_ram (
        .clk_sys(clk_sys),
        .addr(acc_addr[13:1]),
        .wr_en(ram_we),
        .half_en(ram_half),
        .wr_data(ram_wd),
        .rd_data(ram_rdata)
    );

    // ---------------------------------------------------------------
    // flash configuration load at initialisation
    // ---------------------------------------------------------------
    // fetch address issued one cycle, word captured the next
    init_state_t init_reg, init_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [3:0] cap_reg, cap_next;
    logic cap_v_reg, cap_v_next;
    logic [15:0] cfg_reg [CFG_WORDS];

    always_comb begin
        init_next = init_reg;
        cnt_next = cnt_reg;
        cap_next = cnt_reg;
        cap_v_next = 1'b0;
        case (init_reg)
            INIT_LOAD: begin
                cap_v_next = 1'b1;
                if (cnt_reg == 4'(CFG_WORDS - 1)) begin
                    init_next = INIT_DONE;
                end else begin
                    cnt_next = cnt_reg + 4'h1;
                end
            end
            INIT_DONE: cap_v_next = 1'b0;
            default: init_next = INIT_LOAD;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            init_reg <= INIT_LOAD;
            cnt_reg <= '0;
            cap_reg <= '0;
            cap_v_reg <= 1'b0;
            for (int i = 0; i < CFG_WORDS; i++) begin
                cfg_reg[i] <= '0;
            end
        end else begin
            init_reg <= init_next;
            cnt_reg <= cnt_next;
            cap_reg <= cap_next;
            cap_v_reg <= cap_v_next;
            if (cap_v_reg) begin
                cfg_reg[cap_reg] <= pflash_rdata;
            end
        end
    end

    logic [23:0] fetch_reg;
    logic fetch_v_reg, done_reg;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // word 0 is requested while reset is held, so it is ready at the first capture
            fetch_reg <= CFG_FIRST;
            fetch_v_reg <= 1'b1;
            done_reg <= 1'b0;
        end else begin
            fetch_reg <= CFG_FIRST + {20'h0_0000, cnt_next};
            fetch_v_reg <= (init_next == INIT_LOAD);
            done_reg <= (init_reg == INIT_DONE) && !cap_v_reg;
        end
    end

    assign cfg_fetch_addr = fetch_reg;
    assign cfg_fetch_valid = fetch_v_reg;
    assign flash_ctrl_cfg = cfg_reg;
    assign init_done = done_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    periph_window_a: assert property (@(posedge clk_sys) disable iff (rst)
        acc_valid && acc_addr[23:12] == 12'h00F |=> target == 3'(TGT_PERIPH))
        else $error("peripheral window not selected");
    low_disable_a: assert property (@(posedge clk_sys) disable iff (rst)
        acc_valid && internal_memory_disable && acc_addr < 24'h00_8000
        |=> sel_ext && !sel_ram && !sel_dflash)
        else $error("low region decoded on chip while disabled");
    ram_sel_a: assert property (@(posedge clk_sys) disable iff (rst)
        acc_valid && !internal_memory_disable && acc_addr[23:14] == 10'h000 |=> sel_ram)
        else $error("ram not selected");
    dflash_sel_a: assert property (@(posedge clk_sys) disable iff (rst)
        acc_valid && !internal_memory_disable && acc_addr[23:14] == 10'h001
        |=> sel_dflash && dflash_sector == $past(acc_addr[13:10]))
        else $error("data flash decode wrong");
    debug_lock_a: assert property (@(posedge clk_sys) disable iff (rst)
        acc_valid && acc_addr == 24'hFF_FFFC |=> sel_debug && debug_reg == 3'(DBG_LOCK))
        else $error("lock status not selected");
    ext_hole_a: assert property (@(posedge clk_sys) disable iff (rst)
        acc_valid && acc_addr >= 24'h00_8000 && acc_addr <= 24'h00_EFFF |=> sel_ext)
        else $error("hole not sent to external memory");
    one_hot_a: assert property (@(posedge clk_sys) disable iff (rst)
        $onehot0({sel_ram, sel_dflash, sel_periph, sel_debug, sel_ext}))
        else $error("more than one target selected");
    init_len_a: assert property (@(posedge clk_sys)
        $fell(rst) |-> ##[10:12] init_done)
        else $error("config load length wrong");
    pflash_geo_a: assert property (@(posedge clk_sys) disable iff (rst)
        pbus_valid |=> pflash_sector == $past(pbus_addr[17:14]) && pbus_to_boot_or_prog)
        else $error("program flash sector wrong");
endmodule : data_space_decoder

// *** dv/pflash_model.sv ***
// program flash stand-in that answers config fetches one cycle late
module pflash_model (
    input wire logic clk_sys,
    input wire logic [23:0] fetch_addr,
    input wire logic fetch_valid,
    output logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    initial rdata = 16'h0000;
    // content is a fixed scramble of the word address, so each word differs
    // idle cycles invert the output each cycle, so the last word shows again every second idle cycle
    always @(posedge clk_sys) begin
        if (fetch_valid) begin
            rdata <= fetch_addr[15:0] ^ 16'h5A3C;
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule : pflash_model

// *** dv/testbench.sv ***
// self-checking bench for the data-space address decoder
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import dspace_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic internal_memory_disable = 1'b0;
    logic acc_valid = 1'b0;
    logic acc_write = 1'b0;
    logic acc_long = 1'b0;
    logic [23:0] acc_addr = 24'h00_0000;
    logic [31:0] acc_wdata = 32'h0000_0000;
    logic [23:0] pbus_addr = 24'h00_0000;
    logic pbus_valid = 1'b0;
    logic [15:0] pflash_rdata;
    logic [2:0] target, debug_reg;
    logic sel_ram, sel_dflash, sel_periph, sel_debug, sel_ext;
    logic [11:0] periph_offset;
    logic [14:0] dflash_offset;
    logic [3:0] dflash_sector, pflash_sector;
    logic [7:0] dflash_page_word;
    logic pbus_to_boot_or_prog, cfg_fetch_valid, init_done;
    logic [9:0] pflash_page_word;
    logic [31:0] ram_rdata;
    logic [23:0] cfg_fetch_addr;
    logic [15:0] cfg_words [CFG_WORDS];
    logic idis = 1'b0;
    int num_errors = 0;
    int total_checks = 0;
    localparam logic [23:0] MAP_A [12] = '{24'h00_0000, 24'h00_3FFF, 24'h00_4000, 24'h00_7FFF,
        24'h00_8000, 24'h00_EFFF, 24'h00_F000, 24'h00_FFFF, 24'h01_0000, 24'hFF_FEFF,
        24'hFF_FF00, 24'hFF_FFFF};
    localparam logic [2:0] MAP_T [12] = '{TGT_RAM, TGT_RAM, TGT_DFLASH, TGT_DFLASH, TGT_EXT,
        TGT_EXT, TGT_PERIPH, TGT_PERIPH, TGT_EXT, TGT_EXT, TGT_DEBUG, TGT_DEBUG};
    always #12.5 clk_sys = ~clk_sys;
    data_space_decoder dut_u (.clk_sys(clk_sys), .rst(rst),
        .internal_memory_disable(internal_memory_disable), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_long(acc_long), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .pbus_addr(pbus_addr), .pbus_valid(pbus_valid), .pflash_rdata(pflash_rdata),
        .target(target), .sel_ram(sel_ram), .sel_dflash(sel_dflash), .sel_periph(sel_periph),
        .sel_debug(sel_debug), .sel_ext(sel_ext), .debug_reg(debug_reg),
        .periph_offset(periph_offset), .dflash_offset(dflash_offset),
        .dflash_sector(dflash_sector), .dflash_page_word(dflash_page_word),
        .pbus_to_boot_or_prog(pbus_to_boot_or_prog), .pflash_sector(pflash_sector),
        .pflash_page_word(pflash_page_word), .ram_rdata(ram_rdata),
        .cfg_fetch_addr(cfg_fetch_addr), .cfg_fetch_valid(cfg_fetch_valid),
        .flash_ctrl_cfg(cfg_words), .init_done(init_done));
    pflash_model flash_u (.clk_sys(clk_sys), .fetch_addr(cfg_fetch_addr),
        .fetch_valid(cfg_fetch_valid), .rdata(pflash_rdata));
    // ---------------------------------------------------------------
    // shared driving and closing
    // ---------------------------------------------------------------
    // one access is held across the sampling edge; results are read 1 ns later
    task automatic acc(input logic v, input logic [23:0] a, input logic w, input logic l,
            input logic [31:0] d);
        @(posedge clk_sys);
        acc_valid <= v;
        acc_addr <= a;
        acc_write <= w;
        acc_long <= l;
        acc_wdata <= d;
        internal_memory_disable <= idis;
        @(posedge clk_sys);
        #1;
    endtask : acc
    task automatic final_report();
        if (num_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        `CHK("reset target", 3'(TGT_NONE), target)
        `CHK("reset init_done", 1'b0, init_done)
        `CHK("reset cfg word", 16'h0000, cfg_words[0])
    endtask : t_reset
    task automatic t_cfg();
        int n;
        n = 0;
        while (init_done !== 1'b1 && n < 60) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 60) begin
            num_errors++;
            final_report();
        end
        // top nine program words, lowest address in slot 0
        for (int k = 0; k < CFG_WORDS; k++) begin
            `CHK("cfg word", (16'hFFF7 + 16'(k)) ^ 16'h5A3C, cfg_words[k])
        end
        `CHK("fetch idle", 1'b0, cfg_fetch_valid)
    endtask : t_cfg
    task automatic t_map(input logic dis);
        logic [2:0] t;
        idis = dis;
        for (int k = 0; k < 12; k++) begin
            t = (dis && k < 4) ? 3'(TGT_EXT) : MAP_T[k];
            acc(1'b1, MAP_A[k], 1'b0, 1'b0, 32'h0000_0000);
            `CHK("target", t, target)
            `CHK("selects", 5'b1_0000 >> (t - 3'd1),
                {sel_ram, sel_dflash, sel_periph, sel_debug, sel_ext})
            if (t != TGT_DEBUG) `CHK("debug_reg idle", 3'(DBG_OTHER), debug_reg)
        end
        acc(1'b0, 24'h00_0000, 1'b0, 1'b0, 32'h0000_0000);
        `CHK("no access", 3'(TGT_NONE), target)
    endtask : t_map
    task automatic t_debug();
        for (int k = 0; k < 5; k++) begin
            acc(1'b1, k == 0 ? 24'hFF_FF00 : 24'hFF_FFFB + 24'(k), 1'b0, 1'b0, 32'h0);
            `CHK("debug select", 3'(k), debug_reg)
        end
    endtask : t_debug
    task automatic t_offsets();
        idis = 1'b0;
        acc(1'b1, 24'h00_F2A7, 1'b0, 1'b0, 32'h0000_0000);
        `CHK("periph offset", 12'h2A7, periph_offset)
        acc(1'b1, 24'h00_6A5B, 1'b0, 1'b0, 32'h0000_0000);
        `CHK("dflash select", 1'b1, sel_dflash)
        `CHK("dflash offset", 15'h2A5B, dflash_offset)
        `CHK("dflash sector", 4'hA, dflash_sector)
        `CHK("dflash page word", 8'h5B, dflash_page_word)
    endtask : t_offsets
    task automatic t_ram();
        idis = 1'b0;
        acc(1'b1, 24'h00_0010, 1'b1, 1'b1, 32'h1234_5678);
        acc(1'b1, 24'h00_0010, 1'b0, 1'b0, 32'h0000_0000);
        `CHK("long word", 32'h1234_5678, ram_rdata)
        acc(1'b1, 24'h00_0011, 1'b1, 1'b0, 32'h0000_BEEF);
        acc(1'b1, 24'h00_0010, 1'b0, 1'b0, 32'h0000_0000);
        `CHK("upper half", 32'hBEEF_5678, ram_rdata)
        idis = 1'b1;
        acc(1'b1, 24'h00_0010, 1'b1, 1'b0, 32'h0000_CAFE);
        acc(1'b0, 24'h00_0010, 1'b0, 1'b0, 32'h0000_0000);
        idis = 1'b0;
        acc(1'b1, 24'h00_0010, 1'b0, 1'b0, 32'h0000_0000);
        `CHK("masked write", 32'hBEEF_5678, ram_rdata)
    endtask : t_ram
    task automatic t_pbus();
        @(posedge clk_sys);
        pbus_addr <= 24'h02_C7A5;
        pbus_valid <= 1'b1;
        @(posedge clk_sys);
        #1;
        `CHK("pbus strobe", 1'b1, pbus_to_boot_or_prog)
        `CHK("pflash sector", 4'hB, pflash_sector)
        `CHK("pflash page word", 10'h3A5, pflash_page_word)
        @(posedge clk_sys);
        pbus_valid <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK("pbus idle", 1'b0, pbus_to_boot_or_prog)
    endtask : t_pbus
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        t_reset();
        @(posedge clk_sys);
        rst <= 1'b0;
        t_cfg();
        t_map(1'b0);
        t_map(1'b1);
        t_debug();
        t_offsets();
        t_ram();
        t_pbus();
        final_report();
    end
endmodule : testbench
